// file: adc_serial_conversion_control_tb.sv
// Bench: two converter and host pairs, one for each serial clock polarity.
`timescale 1ns/1ns
module adc_serial_conversion_control_tb
	import ascc_pkg::*;
;
	localparam int CONV = 40;
	localparam int WAKE = 5;
	logic        clock_in;
	logic        dev_clk;
	logic        arst_n_in;
	logic        start_in;
	logic        cont_in;
	logic [21:0] sample_in;
	logic [21:0] offset_in;
	logic        ovh_in;
	logic        ovl_in;
	logic        osc_run;
	logic        osc_run1;
	logic        pend;
	logic        valid;
	logic        valid1;
	logic        busy;
	logic        busy1;
	logic [23:0] result;
	logic [23:0] result1;
	logic [23:0] last1_q;
	int          err_count;
	int          checks;

	////////////////////////////////////////////////////////////
	ascc_link_if link0 ();
	ascc_link_if link1 ();
	ascc_device #(.CONV_CYCLES(CONV), .WAKE_CYCLES(WAKE)) ascc_device_inst (
		.clock_in(dev_clk), .arst_n_in(arst_n_in), .link(link0), .sample_in(sample_in),
		.offset_in(offset_in), .ovh_in(ovh_in), .ovl_in(ovl_in), .osc_run_out(osc_run),
		.result_pend_out(pend));
	ascc_host #(.CPOL(1'h1)) ascc_host_inst (.clock_in(clock_in), .arst_n_in(arst_n_in),
		.start_in(start_in), .cont_in(cont_in), .link(link0), .result_out(result),
		.result_valid_out(valid), .busy_out(busy));
	ascc_device #(.CONV_CYCLES(CONV), .WAKE_CYCLES(WAKE)) ascc_device_mode0_inst (
		.clock_in(dev_clk), .arst_n_in(arst_n_in), .link(link1), .sample_in(sample_in),
		.offset_in(offset_in), .ovh_in(ovh_in), .ovl_in(ovl_in), .osc_run_out(osc_run1),
		.result_pend_out());
	ascc_host #(.CPOL(1'h0)) ascc_host_mode0_inst (.clock_in(clock_in), .arst_n_in(arst_n_in),
		.start_in(start_in), .cont_in(cont_in), .link(link1), .result_out(result1),
		.result_valid_out(valid1), .busy_out(busy1));
	ascc_link_asserts #(.CONV_CYCLES(CONV), .WAKE_CYCLES(WAKE)) ascc_link_asserts_inst (
		.clock_in(clock_in), .dev_clock_in(dev_clk), .arst_n_in(arst_n_in),
		.cs_n(link0.cs_n), .sck(link0.sck), .data_ready_d(link0.data_ready_d),
		.data_ready_oe_n(link0.data_ready_oe_n), .data_ready(link0.data_ready),
		.osc_run_out(osc_run), .result_pend_out(pend));

	// Host clock at 20 MHz; converter clock at 30 ns with an unrelated phase.
	initial begin
		clock_in = 1'h0;
		forever #25 clock_in = ~clock_in;
	end
	initial begin
		dev_clk = 1'h0;
		#7;
		forever #15 dev_clk = ~dev_clk;
	end

	// Keeps the last word of the second pair.
	always @(posedge clock_in) begin
		if (valid1 === 1'h1) begin
			last1_q <= result1;
		end
	end

	// Expected word: overflow bits, then sample less offset.
	function automatic logic [23:0] exp_word(input logic [1:0] ov, input logic [21:0] s,
		input logic [21:0] o);
		return {ov, s - o};
	endfunction

	// Compares one value and counts it.
	task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Prints the verdict and stops.
	task automatic end_sim();
		if (err_count == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Starts both hosts when asked, then waits for the next word.
	task automatic word(input bit go, output logic [23:0] w);
		int n;
		if (go) begin
			for (n = 0; n < 300 && (busy !== 1'h0 || busy1 !== 1'h0); n++) begin
				@(posedge clock_in);
			end
			start_in <= 1'h1;
			for (n = 0; n < 50 && (busy !== 1'h1 || busy1 !== 1'h1); n++) begin
				@(posedge clock_in);
			end
			start_in <= 1'h0;
		end
		@(negedge clock_in);
		for (n = 0; n < 3000 && valid !== 1'h1; n++) begin
			@(negedge clock_in);
		end
		check("word_valid", {23'h0, valid}, 24'h1);
		w = result;
	endtask

	// Cuts a hang short.
	initial begin
		repeat (20000) @(posedge clock_in);
		err_count++;
		end_sim();
	end

	// Reads corner and random words in single and continuous use.
	initial begin
		logic [23:0] w, cur, prev;
		logic [21:0] s, o;
		logic [1:0]  ov;
		int          n;
		bit          stale;
		err_count = 0;
		checks = 0;
		arst_n_in = 1'h0;
		start_in = 1'h0;
		cont_in = 1'h0;
		sample_in = 22'h0;
		offset_in = 22'h0;
		ovh_in = 1'h0;
		ovl_in = 1'h0;
		cur = 24'h0;
		void'($urandom(32'hB860));
		repeat (4) @(posedge clock_in);
		arst_n_in <= 1'h1;
		for (int i = 0; i < 9; i++) begin
			for (n = 0; n < 600 && (osc_run !== 1'h0 || osc_run1 !== 1'h0 || busy1 !== 1'h0);
				n++) begin
				@(negedge clock_in);
			end
			check("osc_idle", {23'h0, osc_run}, 24'h0);
			check("osc_idle_mode0", {23'h0, osc_run1}, 24'h0);
			// An unread result is held and is what the next select reads first.
			stale = (pend === 1'h1);
			if (i > 0) begin
				check("mode0_word", last1_q, cur);
			end
			prev = cur;
			s = (i == 0 || i == 1) ? 22'h0 : (i == 2) ? 22'h1FFFFF : 22'($urandom());
			o = (i == 1) ? 22'h1 : (i < 3) ? 22'h0 : 22'($urandom());
			ov = 2'($urandom());
			cur = exp_word(ov, s, o);
			@(posedge clock_in);
			sample_in <= s;
			offset_in <= o;
			{ovh_in, ovl_in} <= ov;
			cont_in <= (i % 3 == 2);
			word(1'h1, w);
			check("word_first", w, stale ? prev : cur);
			if (i % 3 == 2) begin
				for (int k = 0; k < 2; k++) begin
					word(1'h0, w);
					check("word_cont", w, cur);
				end
				@(posedge clock_in);
				cont_in <= 1'h0;
			end
			word(i % 3 != 2, w);
			check("word_last", w, cur);
		end
		for (n = 0; n < 600 && busy1 !== 1'h0; n++) begin
			@(negedge clock_in);
		end
		check("mode0_word", last1_q, cur);
		end_sim();
	end
endmodule

// file: ascc_device.sv
// Converter end: conversion sequencing on the oscillator clock, readout on the serial clock.
`timescale 1ns/1ns
module ascc_device
	import ascc_pkg::*;
#(
	parameter int CONV_CYCLES = CONV_OSC_PERIODS,
	parameter int WAKE_CYCLES = WAKE_OSC_PERIODS
) (
	// Oscillator clock and reset.
	input  wire logic                 clock_in,
	input  wire logic                 arst_n_in,
	// Serial link.
	ascc_link_if.device               link,
	// Converter core.
	input  wire logic [DATA_BITS-1:0] sample_in,
	input  wire logic [DATA_BITS-1:0] offset_in,
	input  wire logic                 ovh_in,
	input  wire logic                 ovl_in,
	// Status.
	output logic                      osc_run_out,
	output logic                      result_pend_out
);

	localparam int CNT_W = $clog2(CONV_CYCLES + WAKE_CYCLES + 1);
	localparam logic [CNT_W-1:0] FIRST_LOAD = CNT_W'(CONV_CYCLES + WAKE_CYCLES - 1);
	localparam logic [CNT_W-1:0] NEXT_LOAD  = CNT_W'(CONV_CYCLES - 1);
	localparam logic [BIT_CNT_W-1:0] LAST_BIT = BIT_CNT_W'(WORD_BITS - 1);
	localparam logic [BIT_CNT_W-1:0] ALL_BITS = BIT_CNT_W'(WORD_BITS);

	ascc_conv_t              state_q;
	logic [CNT_W-1:0]        cnt_q;
	logic                    first_q;
	logic                    single_q;
	logic                    cs_meta_q;
	logic                    cs_sync_q;
	logic                    cs_prev_q;
	logic                    rd_meta_q;
	logic                    rd_sync_q;
	logic                    rd_prev_q;
	logic [DATA_BITS-1:0]    cal_q;
	logic [WORD_BITS-1:0]    res_q;
	logic                    clr_q;
	logic                    ready_q;
	logic                    osc_run_q;
	logic [BIT_CNT_W-1:0]    bit_cnt_q;
	logic                    out_q;
	logic                    rd_tgl_q;
	logic                    done_q;
	logic                    cs_fall;
	logic                    conv_end;
	logic                    publish;
	logic                    rd_done;
	logic                    sh_rst_n;

	////////////////////////////////////////////////////////////////////////////////
	// Chip select and readout-done toggle are brought into the oscillator domain.
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cs_meta_q <= 1'b0;
			cs_sync_q <= 1'b0;
			cs_prev_q <= 1'b0;
			rd_meta_q <= 1'b0;
			rd_sync_q <= 1'b0;
			rd_prev_q <= 1'b0;
		end else begin
			cs_meta_q <= ~link.cs_n;
			cs_sync_q <= cs_meta_q;
			cs_prev_q <= cs_sync_q;
			rd_meta_q <= rd_tgl_q;
			rd_sync_q <= rd_meta_q;
			rd_prev_q <= rd_sync_q;
		end
	end

	// The select flag resets to idle, so a select tied low looks like a fall at release.
	assign cs_fall  = cs_sync_q & ~cs_prev_q;
	assign conv_end = (state_q == CV_CONV) && (cnt_q == '0);
	assign publish  = conv_end && !ready_q;
	assign rd_done  = rd_sync_q ^ rd_prev_q;

	////////////////////////////////////////////////////////////////////////////////
	// Conversion sequencer: shutdown until a select fall, then timed conversions.
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_q  <= CV_SHUT;
			cnt_q    <= '0;
			first_q  <= 1'b0;
			single_q <= 1'b0;
		end else begin
			case (state_q)
				CV_SHUT: begin
					if (cs_fall) begin
						state_q  <= CV_CONV;
						cnt_q    <= FIRST_LOAD;
						first_q  <= 1'b1;
						single_q <= 1'b0;
					end
				end
				CV_CONV: begin
					if (first_q && !cs_sync_q) begin
						single_q <= 1'b1;
					end
					if (conv_end) begin
						first_q <= 1'b0;
						if (cs_sync_q && !single_q && !(first_q && !cs_sync_q)) begin
							cnt_q <= NEXT_LOAD;
						end else begin
							state_q <= CV_SHUT;
						end
					end else begin
						cnt_q <= cnt_q - 1'b1;
					end
				end
				default: begin
					state_q <= CV_SHUT;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Calibration is taken at the start of each conversion and applied at its end.
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cal_q <= '0;
		end else if ((state_q == CV_SHUT && cs_fall) || (conv_end && state_q == CV_CONV)) begin
			cal_q <= offset_in;
		end
	end

	// Result word: overflow bits on top, two's complement data below.
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			res_q <= '0;
		end else if (publish) begin
			res_q[OVH_POS]         <= ovh_in;
			res_q[OVL_POS]         <= ovl_in;
			res_q[DATA_BITS-1:0]   <= sample_in - cal_q;
		end
	end

	// A fresh result first clears the shifter, then raises ready; an unread one is kept.
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			clr_q   <= 1'b0;
			ready_q <= 1'b0;
		end else begin
			clr_q <= publish;
			if (clr_q) begin
				ready_q <= 1'b1;
			end else if (rd_done) begin
				ready_q <= 1'b0;
			end
		end
	end

	// Status outputs.
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			osc_run_q <= 1'b0;
		end else begin
			osc_run_q <= (state_q == CV_CONV);
		end
	end

	assign osc_run_out     = osc_run_q;
	assign result_pend_out = ready_q;

	////////////////////////////////////////////////////////////////////////////////
	// Serial shifter, held in reset while deselected or while a new result loads.
	assign sh_rst_n = arst_n_in & ~link.cs_n & ~clr_q;

	always_ff @(negedge link.sck or negedge sh_rst_n) begin
		if (!sh_rst_n) begin
			bit_cnt_q <= '0;
			out_q     <= 1'b1;
		end else if (ready_q && bit_cnt_q != ALL_BITS) begin
			out_q     <= res_q[LAST_BIT - bit_cnt_q];
			bit_cnt_q <= bit_cnt_q + 1'b1;
		end
	end

	// Marks that the word has been closed, so later rises do not toggle again.
	always_ff @(posedge link.sck or negedge sh_rst_n) begin
		if (!sh_rst_n) begin
			done_q <= 1'b0;
		end else if (bit_cnt_q == ALL_BITS) begin
			done_q <= 1'b1;
		end
	end

	// The done toggle fires on the rise after the last fall, so the last bit stands
	// until the host has sampled it; it survives deselection so no readout is missed.
	always_ff @(posedge link.sck or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rd_tgl_q <= 1'b0;
		end else if (!link.cs_n && ready_q && bit_cnt_q == ALL_BITS && !done_q) begin
			rd_tgl_q <= ~rd_tgl_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin drive: low for ready, shifted bits while reading, high otherwise.
	assign link.data_ready_d    = !ready_q ? 1'b1 :
	                              (bit_cnt_q == '0) ? 1'b0 : out_q;
	assign link.data_ready_oe_n = link.cs_n;

endmodule

// file: ascc_host.sv
// Host end: makes the serial clock by division, selects, waits for ready, reads 24 bits.
`timescale 1ns/1ns
module ascc_host
	import ascc_pkg::*;
#(
	parameter bit CPOL      = 1'b1,
	parameter int HALF_CYC  = SCK_HALF_CYC,
	parameter int SETTLE    = RDY_SETTLE_CYC
) (
	// System clock and reset.
	input  wire logic                 clock_in,
	input  wire logic                 arst_n_in,
	// User requests.
	input  wire logic                 start_in,
	input  wire logic                 cont_in,
	// Serial link.
	ascc_link_if.host                 link,
	// Results.
	output logic [WORD_BITS-1:0]      result_out,
	output logic                      result_valid_out,
	output logic                      busy_out
);

	localparam int DIV_W = $clog2(HALF_CYC + 1);
	localparam int SET_W = $clog2(SETTLE + CSL_MIN_CYC + 1);
	localparam logic [DIV_W-1:0]     DIV_LAST = DIV_W'(HALF_CYC - 1);
	localparam logic [SET_W-1:0]     SET_LOAD = SET_W'(SETTLE + CSL_MIN_CYC);
	localparam logic [BIT_CNT_W-1:0] LAST_BIT = BIT_CNT_W'(WORD_BITS - 1);

	ascc_host_t            state_q;
	logic [DIV_W-1:0]      div_q;
	logic [SET_W-1:0]      settle_q;
	logic [BIT_CNT_W-1:0]  bits_q;
	logic                  armed_q;
	logic                  sck_q;
	logic                  cs_n_q;
	logic                  dr_meta_q;
	logic                  dr_sync_q;
	logic [WORD_BITS-1:0]  shreg_q;
	logic [WORD_BITS-1:0]  result_q;
	logic                  valid_q;
	logic                  busy_q;

	////////////////////////////////////////////////////////////////////////////////
	// The data/ready pin comes from the converter's domain.
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			dr_meta_q <= 1'b1;
			dr_sync_q <= 1'b1;
		end else begin
			dr_meta_q <= link.data_ready;
			dr_sync_q <= dr_meta_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Transfer sequencer; the serial clock toggles every HALF_CYC system cycles.
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_q  <= HS_IDLE;
			div_q    <= '0;
			settle_q <= '0;
			bits_q   <= '0;
			armed_q  <= 1'b0;
			sck_q    <= CPOL;
			cs_n_q   <= 1'b1;
			shreg_q  <= '0;
			result_q <= '0;
			valid_q  <= 1'b0;
		end else begin
			valid_q <= 1'b0;
			case (state_q)
				HS_IDLE: begin
					sck_q <= CPOL;
					if (start_in) begin
						cs_n_q   <= 1'b0;
						settle_q <= SET_LOAD;
						state_q  <= HS_WAIT;
					end
				end
				HS_WAIT: begin
					if (settle_q != '0) begin
						settle_q <= settle_q - 1'b1;
					end else if (!dr_sync_q) begin
						div_q   <= '0;
						bits_q  <= '0;
						armed_q <= 1'b0;
						state_q <= HS_SHIFT;
					end
				end
				HS_SHIFT: begin
					if (div_q != DIV_LAST) begin
						div_q <= div_q + 1'b1;
					end else begin
						div_q <= '0;
						if (!sck_q) begin
							sck_q <= 1'b1;
						end else if (armed_q && bits_q == LAST_BIT) begin
							result_q <= {shreg_q[WORD_BITS-2:0], dr_sync_q};
							valid_q  <= 1'b1;
							sck_q    <= CPOL;
							settle_q <= SET_LOAD;
							if (cont_in) begin
								state_q <= HS_WAIT;
							end else begin
								cs_n_q  <= 1'b1;
								state_q <= HS_IDLE;
							end
						end else begin
							if (armed_q) begin
								shreg_q <= {shreg_q[WORD_BITS-2:0], dr_sync_q};
								bits_q  <= bits_q + 1'b1;
							end
							armed_q <= 1'b1;
							sck_q   <= 1'b0;
						end
					end
				end
				default: begin
					state_q <= HS_IDLE;
				end
			endcase
		end
	end

	// Busy flag.
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			busy_q <= 1'b0;
		end else begin
			busy_q <= (state_q != HS_IDLE) || start_in;
		end
	end

	assign link.cs_n        = cs_n_q;
	assign link.sck         = sck_q;
	assign result_out       = result_q;
	assign result_valid_out = valid_q;
	assign busy_out         = busy_q;

endmodule

// file: ascc_link_asserts.sv
// Checker for the serial link and the converter status.
`timescale 1ns/1ns
module ascc_link_asserts
	import ascc_pkg::*;
#(
	parameter int CONV_CYCLES = CONV_OSC_PERIODS,
	parameter int WAKE_CYCLES = WAKE_OSC_PERIODS
) (
	// Clocks and reset.
	input  wire logic clock_in,
	input  wire logic dev_clock_in,
	input  wire logic arst_n_in,
	// Link.
	input  wire logic cs_n,
	input  wire logic sck,
	input  wire logic data_ready_d,
	input  wire logic data_ready_oe_n,
	input  wire logic data_ready,
	// Converter status.
	input  wire logic osc_run_out,
	input  wire logic result_pend_out
);
	localparam int WAKE_LO = CONV_CYCLES + WAKE_CYCLES - 3;
	localparam int WAKE_HI = CONV_CYCLES + WAKE_CYCLES + 3;
	logic        sck_q;
	logic [4:0]  fall_cnt_q;
	logic        osc_q;
	logic        first_q;
	logic [15:0] conv_cnt_q;

	////////////////////////////////////////////////////////////
	// Counts serial clock falls within one word.
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			sck_q      <= 1'h1;
			fall_cnt_q <= 5'h00;
		end else begin
			sck_q <= sck;
			if (cs_n || (fall_cnt_q == 5'h18 && data_ready_d)) begin
				fall_cnt_q <= 5'h00;
			end else if (sck_q && !sck) begin
				fall_cnt_q <= fall_cnt_q + 5'h01;
			end
		end
	end

	// Times a conversion started from shutdown with nothing pending.
	always_ff @(posedge dev_clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			osc_q      <= 1'h0;
			first_q    <= 1'h0;
			conv_cnt_q <= 16'h0000;
		end else begin
			osc_q <= osc_run_out;
			if (osc_run_out && !osc_q) begin
				conv_cnt_q <= 16'h0001;
				first_q    <= !result_pend_out;
			end else begin
				if (conv_cnt_q != 16'hFFFF) begin
					conv_cnt_q <= conv_cnt_q + 16'h0001;
				end
				if (result_pend_out) begin
					first_q <= 1'h0;
				end
			end
		end
	end

	// Steps of a readout: ready shown, then a cycle with no clock fall.
	sequence ready_low_s;
		!cs_n && fall_cnt_q == 5'h00 && !data_ready_d;
	endsequence
	sequence no_fall_s;
		!cs_n && !$fell(sck);
	endsequence

	oe_follows_cs_a: assert property (
		@(posedge clock_in) disable iff (!arst_n_in) data_ready_oe_n == cs_n)
		else $error("Output enable does not follow chip select.");
	wire_released_a: assert property (
		@(posedge clock_in) disable iff (!arst_n_in) cs_n |-> data_ready)
		else $error("Data line driven while deselected.");
	bit_hold_a: assert property (
		@(posedge clock_in) disable iff (!arst_n_in)
		(!cs_n && fall_cnt_q inside {[5'h01:5'h17]} && !$fell(sck)) |-> $stable(data_ready_d))
		else $error("Data bit changed without a clock fall.");
	ready_stands_a: assert property (
		@(posedge clock_in) disable iff (!arst_n_in) ready_low_s ##1 no_fall_s |-> !data_ready_d)
		else $error("Ready flag left before the first clock fall.");
	word_end_a: assert property (
		@(posedge clock_in) disable iff (!arst_n_in)
		($fell(sck) && !cs_n && fall_cnt_q == 5'h17) |-> ##[0:8] data_ready_d)
		else $error("Ready not cleared after the last bit.");
	ready_shown_a: assert property (
		@(posedge dev_clock_in) disable iff (!arst_n_in)
		($rose(result_pend_out) && !cs_n) |-> ##[0:1] !data_ready_d)
		else $error("New result not flagged on the data line.");
	busy_high_a: assert property (
		@(posedge dev_clock_in) disable iff (!arst_n_in)
		(osc_run_out && !result_pend_out && !cs_n) |-> data_ready_d)
		else $error("Data line low while converting.");
	no_start_a: assert property (
		@(posedge dev_clock_in) disable iff (!arst_n_in) (cs_n && !osc_run_out) |=> !osc_run_out)
		else $error("Conversion started without a select fall.");
	wake_time_a: assert property (
		@(posedge dev_clock_in) disable iff (!arst_n_in)
		($rose(result_pend_out) && first_q) |-> (conv_cnt_q >= WAKE_LO && conv_cnt_q <= WAKE_HI))
		else $error("First conversion time is wrong.");
endmodule

// file: ascc_link_if.sv
// Serial link between the converter and its host, with the shared data/ready wire.
`timescale 1ns/1ns
interface ascc_link_if;
	logic cs_n;
	logic sck;
	logic data_ready_d;
	logic data_ready_oe_n;
	logic data_ready;

	// The undriven wire reads high, as a pull-up would make it.
	assign data_ready = data_ready_oe_n ? 1'b1 : data_ready_d;

	modport device (
		input  cs_n,
		input  sck,
		output data_ready_d,
		output data_ready_oe_n
	);

	modport host (
		output cs_n,
		output sck,
		input  data_ready
	);
endinterface

// file: ascc_pkg.sv
// Shared constants and types for the serial conversion controller and its host.
package ascc_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Result word layout.
	localparam int WORD_BITS   = 24;
	localparam int DATA_BITS   = 22;
	localparam int OVH_POS     = 23;
	localparam int OVL_POS     = 22;
	localparam int BIT_CNT_W   = 5;

	////////////////////////////////////////////////////////////////////////////////
	// Conversion timing, counted in internal oscillator periods.
	localparam int CONV_OSC_PERIODS = 8192;
	localparam int WAKE_OSC_PERIODS = 144;

	////////////////////////////////////////////////////////////////////////////////
	// Host timing: system clock, fastest serial clock, least chip-select low time.
	localparam longint CLK_HZ       = 20000000;
	localparam longint SCK_MAX_HZ   = 5000000;
	localparam int     CLK_PERIOD_NS = 50;
	localparam int     CSL_MIN_NS   = 50;
	localparam int     SCK_HALF_CYC = int'((CLK_HZ + 2 * SCK_MAX_HZ - 1) / (2 * SCK_MAX_HZ));
	localparam int     CSL_MIN_CYC  = (CSL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int     RDY_SETTLE_CYC = 6;

	////////////////////////////////////////////////////////////////////////////////
	// State encodings.
	typedef enum logic [0:0] {
		CV_SHUT = 1'b0,
		CV_CONV = 1'b1
	} ascc_conv_t;

	typedef enum logic [1:0] {
		HS_IDLE  = 2'b00,
		HS_WAIT  = 2'b01,
		HS_SHIFT = 2'b10
	} ascc_host_t;

endpackage
